// File: bfsp_top.sv
// Fail-safe sequencer of the bus-loss positioner with APB registers
// Contract
// - Flag bus loss after 25000 consecutive empty frame slots.
// - Sleep-allow 0 forbids sleep after bus loss; 1 allows it.
// - Sleep-allow defaults to disabled.
// - Recovery bit 0: no referencing run on bus loss.
// - Recovery bit 1: referencing run unless already referenced.
// - Autonomous motion only after loss, with recovery 1 or safe position not 0x400.
// - Referenced device moves absolutely to the safe position.
// - Unreferenced: half-range move to stall with OTP parameters, negative unless invert is set.
// - At end stop clear current position to zero.
// - Then move a further 10 full steps.
// - Final move to safe position, skipped when it equals 0x400.
// - Use the 11-bit safe position held in RAM.
// - Safe move copies safe position into target position.
// - Operating case ends in stop or sleep by sleep-allow.
// - Operating case uses 11-bit safe position resolution.
// - Floating strap acts as bus loss; no sleep while bus alive.
// - Power-on loss, recovery 0: absolute safe move.
// - Power-on loss, recovery 1: stall half-range run, zero, invert sets direction.
// - Power-on second move uses OTP data, direction from bit 10 xor invert.
// - Power-on case uses only 9 upper bits of safe position.
// - Power-on sequence ends in stop or sleep by sleep-allow.
// - Strap-caused power-on run never enters sleep.
`timescale 1ns/1ps
module bfsp_top #(
    parameter int          LOSS_FRAMES = bfsp_pkg::LOSS_FRAMES,
    parameter logic [15:0] HALF_RANGE  = bfsp_pkg::HALF_RANGE_DEF
) (
    // Clock and reset
    input  wire logic        clock_i,
    input  wire logic        rst_i,
    // APB slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // Pins
    input  wire logic        address_strap_two_i,
    // Motion request to profile generator
    output bfsp_pkg::bfsp_move_t move_o,
    output logic             stop_o,
    output logic             sleep_o,
    output logic             bus_lost_o
);
    // ------------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------------
    logic strap_m_q;
    logic strap_s_q;

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            strap_m_q <= 1'b0;
            strap_s_q <= 1'b0;
        end else begin
            strap_m_q <= address_strap_two_i;
            strap_s_q <= strap_m_q;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [2:0]  otp_q;
    logic        poweron_q;
    logic [10:0] safe_target_position_q;
    logic [15:0] current_position_q;
    logic [15:0] target_position_q;
    logic        referenced_q;
    logic        bus_seen_q;
    logic        strap_cause_q;
    logic        lost;
    bfsp_pkg::bfsp_state_t state_q;

    logic wr_en;
    logic ev_slot;
    logic ev_frame;
    logic ev_twostg;
    logic ev_posrst;
    logic ev_mdone;
    logic ev_stall;

    assign wr_en     = psel_i && penable_i && pwrite_i;
    assign ev_slot   = wr_en && paddr_i == bfsp_pkg::ADDR_CTRL
                       && pwdata_i[bfsp_pkg::CTRL_STRAP_BIT];
    assign ev_frame  = wr_en && paddr_i == bfsp_pkg::ADDR_CTRL
                       && pwdata_i[bfsp_pkg::CTRL_FRAME_BIT];
    assign ev_twostg = wr_en && paddr_i == bfsp_pkg::ADDR_CTRL
                       && pwdata_i[bfsp_pkg::CTRL_TWOSTG_BIT];
    assign ev_posrst = wr_en && paddr_i == bfsp_pkg::ADDR_CTRL
                       && pwdata_i[bfsp_pkg::CTRL_POSRST_BIT];
    assign ev_mdone  = wr_en && paddr_i == bfsp_pkg::ADDR_CTRL
                       && pwdata_i[bfsp_pkg::CTRL_MDONE_BIT];
    assign ev_stall  = wr_en && paddr_i == bfsp_pkg::ADDR_CTRL
                       && pwdata_i[bfsp_pkg::CTRL_STALL_BIT];

    // OTP shadow: sleep-allow, recovery, direction invert; power-on case flag
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            otp_q     <= bfsp_pkg::OTP_RST;
            poweron_q <= 1'b1;
        end else if (wr_en && paddr_i == bfsp_pkg::ADDR_OTP) begin
            otp_q     <= pwdata_i[2:0];
            poweron_q <= pwdata_i[bfsp_pkg::OTP_POWERON_BIT];
        end else if (ev_frame) begin
            poweron_q <= 1'b0;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            safe_target_position_q <= bfsp_pkg::SAFE_POS_RST;
        end else if (wr_en && paddr_i == bfsp_pkg::ADDR_SAFE) begin
            safe_target_position_q <= pwdata_i[10:0];
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            referenced_q <= 1'b0;
        end else if (ev_twostg || ev_posrst) begin
            referenced_q <= 1'b1;
        end else if (state_q == bfsp_pkg::ST_SETWT && ev_mdone) begin
            referenced_q <= 1'b1;
        end
    end

    // Bus alive since last loss
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            bus_seen_q <= 1'b0;
        end else if (ev_frame) begin
            bus_seen_q <= 1'b1;
        end else if (lost) begin
            bus_seen_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Bus-loss detection
    // ------------------------------------------------------------------
    bfsp_loss_timer #(
        .LIMIT      (LOSS_FRAMES)
    ) u_timer (
        .clock_i    (clock_i),
        .rst_i      (rst_i),
        .slot_i     (ev_slot),
        .frame_ok_i (ev_frame),
        .lost_o     (lost)
    );

    logic trigger;
    assign trigger = lost || strap_s_q;

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    logic        safe_valid;
    logic [10:0] safe_eff;
    logic        use_ref;

    assign safe_eff   = poweron_q ? {safe_target_position_q[10:2], 2'b00}
                                  : safe_target_position_q;
    assign safe_valid = safe_target_position_q != bfsp_pkg::SAFE_POS_NONE;
    assign use_ref    = otp_q[bfsp_pkg::OTP_RECOV_BIT] && !referenced_q;

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            state_q <= bfsp_pkg::ST_RUN;
        end else begin
            unique case (state_q)
                bfsp_pkg::ST_RUN: begin
                    if (trigger) begin
                        state_q <= bfsp_pkg::ST_DECIDE;
                    end
                end
                bfsp_pkg::ST_DECIDE: begin
                    if (use_ref) begin
                        state_q <= bfsp_pkg::ST_REFGO;
                    end else if (safe_valid) begin
                        state_q <= bfsp_pkg::ST_SAFEGO;
                    end else begin
                        state_q <= bfsp_pkg::ST_PARK;
                    end
                end
                bfsp_pkg::ST_REFGO:  state_q <= bfsp_pkg::ST_REFWT;
                bfsp_pkg::ST_REFWT: begin
                    if (ev_stall || ev_mdone) begin
                        state_q <= poweron_q ? (safe_valid ? bfsp_pkg::ST_SAFEGO
                                                           : bfsp_pkg::ST_PARK)
                                             : bfsp_pkg::ST_SETGO;
                    end
                end
                bfsp_pkg::ST_SETGO:  state_q <= bfsp_pkg::ST_SETWT;
                bfsp_pkg::ST_SETWT: begin
                    if (ev_mdone) begin
                        state_q <= safe_valid ? bfsp_pkg::ST_SAFEGO
                                              : bfsp_pkg::ST_PARK;
                    end
                end
                bfsp_pkg::ST_SAFEGO: state_q <= bfsp_pkg::ST_SAFEWT;
                bfsp_pkg::ST_SAFEWT: begin
                    if (ev_mdone) begin
                        state_q <= bfsp_pkg::ST_PARK;
                    end
                end
                bfsp_pkg::ST_PARK: begin
                    if (ev_frame) begin
                        state_q <= bfsp_pkg::ST_RUN;
                    end
                end
                default: state_q <= bfsp_pkg::ST_RUN;
            endcase
        end
    end

    // Cause latched at trigger for sleep decision
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            strap_cause_q <= 1'b0;
        end else if (state_q == bfsp_pkg::ST_RUN && trigger) begin
            strap_cause_q <= !lost;
        end
    end

    // Position registers
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            current_position_q <= 16'h0000;
        end else if (ev_posrst) begin
            current_position_q <= 16'h0000;
        end else if (state_q == bfsp_pkg::ST_REFWT && (ev_stall || ev_mdone)) begin
            current_position_q <= 16'h0000;
        end else if (wr_en && paddr_i == bfsp_pkg::ADDR_CURPOS) begin
            current_position_q <= pwdata_i[15:0];
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            target_position_q <= 16'h0000;
        end else if (state_q == bfsp_pkg::ST_SAFEGO) begin
            target_position_q <= {{5{safe_eff[10]}}, safe_eff};
        end
    end

    // Move request, one-cycle valid
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            move_o <= '0;
        end else begin
            move_o <= '0;
            unique case (state_q)
                bfsp_pkg::ST_REFGO: begin
                    move_o.valid    <= 1'b1;
                    move_o.relative <= 1'b1;
                    move_o.to_stall <= 1'b1;
                    move_o.use_otp  <= 1'b1;
                    move_o.pos      <= otp_q[bfsp_pkg::OTP_INVERT_BIT] ? HALF_RANGE
                                       : 16'(-HALF_RANGE);
                end
                bfsp_pkg::ST_SETGO: begin
                    move_o.valid    <= 1'b1;
                    move_o.relative <= 1'b1;
                    move_o.use_otp  <= 1'b1;
                    move_o.pos      <= otp_q[bfsp_pkg::OTP_INVERT_BIT]
                                       ? bfsp_pkg::SETTLE_STEPS
                                       : 16'(-bfsp_pkg::SETTLE_STEPS);
                end
                bfsp_pkg::ST_SAFEGO: begin
                    move_o.valid    <= 1'b1;
                    move_o.use_otp  <= poweron_q;
                    move_o.pos      <= {{5{safe_eff[10] ^ (poweron_q
                                       && otp_q[bfsp_pkg::OTP_INVERT_BIT])}},
                                       safe_eff};
                end
                default: ;
            endcase
        end
    end

    // Stop or sleep after sequence
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            stop_o  <= 1'b0;
            sleep_o <= 1'b0;
        end else if (state_q == bfsp_pkg::ST_PARK) begin
            if (otp_q[bfsp_pkg::OTP_SLEEP_BIT] && !strap_cause_q && !bus_seen_q) begin
                sleep_o <= 1'b1;
                stop_o  <= 1'b0;
            end else begin
                sleep_o <= 1'b0;
                stop_o  <= 1'b1;
            end
        end else begin
            stop_o  <= 1'b0;
            sleep_o <= 1'b0;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            bus_lost_o <= 1'b0;
        end else begin
            bus_lost_o <= lost;
        end
    end

    // ------------------------------------------------------------------
    // APB read path, zero wait states
    // ------------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            prdata_o  <= 32'h0000_0000;
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end else begin
            pready_o  <= psel_i && !penable_i;
            pslverr_o <= psel_i && !penable_i && !(paddr_i == bfsp_pkg::ADDR_CTRL
                         || paddr_i == bfsp_pkg::ADDR_OTP || paddr_i == bfsp_pkg::ADDR_SAFE
                         || paddr_i == bfsp_pkg::ADDR_STATUS
                         || paddr_i == bfsp_pkg::ADDR_CURPOS
                         || paddr_i == bfsp_pkg::ADDR_TGTPOS);
            unique case (paddr_i)
                bfsp_pkg::ADDR_OTP:    prdata_o <= {28'h0, poweron_q, otp_q};
                bfsp_pkg::ADDR_SAFE:   prdata_o <= {21'h0, safe_target_position_q};
                bfsp_pkg::ADDR_STATUS: prdata_o <= {24'h0, strap_s_q, referenced_q,
                                                     lost, 1'b0, state_q};
                bfsp_pkg::ADDR_CURPOS: prdata_o <= {16'h0, current_position_q};
                bfsp_pkg::ADDR_TGTPOS: prdata_o <= {16'h0, target_position_q};
                default:               prdata_o <= 32'h0000_0000;
            endcase
        end
    end
endmodule : bfsp_top

// File: bfsp_pkg.sv
// Package of constants and types for the bus-loss fail-safe positioner
package bfsp_pkg;

    // ------------------------------------------------------------------
    // Register map (APB byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_OTP    = 8'h04;
    localparam logic [7:0] ADDR_SAFE   = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_CURPOS = 8'h10;
    localparam logic [7:0] ADDR_TGTPOS = 8'h14;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CTRL_FRAME_BIT   = 0;
    localparam int CTRL_TWOSTG_BIT  = 1;
    localparam int CTRL_POSRST_BIT  = 2;
    localparam int CTRL_MDONE_BIT   = 3;
    localparam int CTRL_STALL_BIT   = 4;
    localparam int CTRL_STRAP_BIT   = 5;
    localparam int OTP_SLEEP_BIT    = 0;
    localparam int OTP_RECOV_BIT    = 1;
    localparam int OTP_INVERT_BIT   = 2;
    localparam int OTP_POWERON_BIT  = 3;

    // ------------------------------------------------------------------
    // Reset values and numeric constants
    // ------------------------------------------------------------------
    localparam logic [10:0] SAFE_POS_RST   = 11'h400;
    localparam logic [10:0] SAFE_POS_NONE  = 11'h400;
    localparam logic [2:0]  OTP_RST        = 3'h0;
    localparam int          LOSS_FRAMES    = 25000;
    localparam logic [15:0] SETTLE_STEPS   = 16'h000A;
    localparam logic [15:0] HALF_RANGE_DEF = 16'h0800;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_RUN    = 4'h0,
        ST_DECIDE = 4'h1,
        ST_REFGO  = 4'h2,
        ST_REFWT  = 4'h3,
        ST_SETGO  = 4'h4,
        ST_SETWT  = 4'h5,
        ST_SAFEGO = 4'h6,
        ST_SAFEWT = 4'h7,
        ST_PARK   = 4'h8
    } bfsp_state_t;

    typedef struct packed {
        logic        valid;
        logic        relative;
        logic        to_stall;
        logic        use_otp;
        logic [15:0] pos;
    } bfsp_move_t;

endpackage : bfsp_pkg

// File: bfsp_loss_timer.sv
// Frame slot counter that flags loss of bus communication
`timescale 1ns/1ps
module bfsp_loss_timer #(
    parameter int LIMIT = bfsp_pkg::LOSS_FRAMES
) (
    // Clock and reset
    input  wire logic clock_i,
    input  wire logic rst_i,
    // Slot events
    input  wire logic slot_i,
    input  wire logic frame_ok_i,
    // Result
    output logic      lost_o
);
    logic [$clog2(LIMIT+1)-1:0] cnt_q;

    // Count empty slots, any good frame restarts
    always_ff @(posedge clock_i) begin
        if (rst_i || frame_ok_i) begin
            cnt_q <= '0;
        end else if (slot_i && cnt_q != LIMIT[$clog2(LIMIT+1)-1:0]) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i || frame_ok_i) begin
            lost_o <= 1'b0;
        end else if (cnt_q == LIMIT[$clog2(LIMIT+1)-1:0]) begin
            lost_o <= 1'b1;
        end
    end
endmodule : bfsp_loss_timer

// File: bfsp_top_chk.sv
// Port checker of the fail-safe positioner
`timescale 1ns/1ps
module bfsp_top_chk #(
    parameter int LOSS_FRAMES = bfsp_pkg::LOSS_FRAMES
) (
    // Clock and reset
    input wire logic                 clock_i,
    input wire logic                 rst_i,
    // APB
    input wire logic                 psel_i,
    input wire logic                 penable_i,
    input wire logic                 pwrite_i,
    input wire logic [7:0]           paddr_i,
    input wire logic [31:0]          pwdata_i,
    input wire logic [31:0]          prdata_o,
    input wire logic                 pready_o,
    input wire logic                 pslverr_o,
    // Pins and motion
    input wire logic                 address_strap_two_i,
    input wire bfsp_pkg::bfsp_move_t move_o,
    input wire logic                 stop_o,
    input wire logic                 sleep_o,
    input wire logic                 bus_lost_o
);
    logic acc;
    logic mapped;
    int   slot_cnt_q;
    logic sleep_en_q;
    logic strap_q;
    assign acc    = psel_i && penable_i && pready_o && pwrite_i;
    assign mapped = paddr_i <= bfsp_pkg::ADDR_TGTPOS && paddr_i[1:0] == 2'h0;
    always_ff @(posedge clock_i) begin
        if (rst_i || (acc && paddr_i == bfsp_pkg::ADDR_CTRL
                      && pwdata_i[bfsp_pkg::CTRL_FRAME_BIT])) slot_cnt_q <= 0;
        else if (acc && paddr_i == bfsp_pkg::ADDR_CTRL && pwdata_i[bfsp_pkg::CTRL_STRAP_BIT]
                 && slot_cnt_q < LOSS_FRAMES)
            slot_cnt_q <= slot_cnt_q + 1;
    end
    always_ff @(posedge clock_i) begin
        if (rst_i) sleep_en_q <= 1'b0;
        else if (acc && paddr_i == bfsp_pkg::ADDR_OTP)
            sleep_en_q <= pwdata_i[bfsp_pkg::OTP_SLEEP_BIT];
    end
    always_ff @(posedge clock_i) begin
        if (rst_i) strap_q <= 1'b0;
        else if (address_strap_two_i) strap_q <= 1'b1;
    end
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    a_loss_count: assert property (
        $rose(bus_lost_o) |-> slot_cnt_q >= LOSS_FRAMES)
        else $error("loss flag before slot count");
    a_loss_prompt: assert property (
        $rose(slot_cnt_q == LOSS_FRAMES) |-> ##[0:3] bus_lost_o)
        else $error("loss flag late");
    a_ready_answer: assert property (psel_i && !penable_i |=> pready_o)
        else $error("no ready after setup");
    a_ready_pulse: assert property (pready_o |=> !pready_o)
        else $error("ready longer than one cycle");
    a_unmapped_err: assert property (pready_o |-> pslverr_o == !mapped)
        else $error("error response wrong");
    a_move_after_loss: assert property (
        move_o.valid |-> bus_lost_o || strap_q)
        else $error("motion without loss");
    a_sleep_allowed: assert property (
        sleep_o |-> sleep_en_q && !strap_q)
        else $error("sleep not allowed");
    a_park_single: assert property (!(stop_o && sleep_o))
        else $error("stop and sleep together");
    a_valid_pulse: assert property (move_o.valid |=> !move_o.valid)
        else $error("move request not a pulse");
    a_park_still: assert property (stop_o || sleep_o |-> !move_o.valid)
        else $error("motion while parked");
    cover property (move_o.valid && move_o.to_stall);
    cover property (move_o.valid && move_o.relative);
    cover property ($rose(sleep_o));
    cover property ($rose(stop_o));
endmodule : bfsp_top_chk

bind bfsp_top bfsp_top_chk #(.LOSS_FRAMES(LOSS_FRAMES)) bfsp_top_chk_i (
    .clock_i(clock_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .address_strap_two_i(address_strap_two_i),
    .move_o(move_o), .stop_o(stop_o), .sleep_o(sleep_o), .bus_lost_o(bus_lost_o));

// File: bfsp_motion_model.sv
// Behavioural profile generator answering move requests
`timescale 1ns/1ps
module bfsp_motion_model (
    // Clock and reset
    input  wire logic                 clock_i,
    input  wire logic                 rst_i,
    // Move request and answer
    input  wire bfsp_pkg::bfsp_move_t move_i,
    input  wire logic                 ack_i,
    output logic                      done_o
);
    int   wait_q;
    logic busy_q;
    // Done holds until acknowledged, after a random run time
    always_ff @(posedge clock_i) begin
        if (rst_i || ack_i) done_o <= 1'b0;
        else if (busy_q && wait_q == 0) done_o <= 1'b1;
        if (rst_i) busy_q <= 1'b0;
        else if (move_i.valid) busy_q <= 1'b1;
        else if (wait_q == 0) busy_q <= 1'b0;
        if (move_i.valid) wait_q <= $urandom_range(40, 1);
        else if (wait_q > 0) wait_q <= wait_q - 1;
    end
endmodule : bfsp_motion_model

// File: bfsp_top_tb.sv
// Self-checking testbench of the fail-safe positioner
`timescale 1ns/1ps
module bfsp_top_tb;
    localparam int LOSS = 4;
    logic                 clock_i, rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
    logic                 address_strap_two_i, stop_o, sleep_o, bus_lost_o, ack, done, err;
    logic [7:0]           paddr_i;
    logic [31:0]          pwdata_i, prdata_o, rd;
    bfsp_pkg::bfsp_move_t move_o;
    bfsp_pkg::bfsp_move_t seen_q[$];
    logic [17:0]          exp_q[$];
    int                   fail_count, compares;

    bfsp_top #(.LOSS_FRAMES(LOSS)) bfsp_top_i (
        .clock_i(clock_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .address_strap_two_i(address_strap_two_i),
        .move_o(move_o), .stop_o(stop_o), .sleep_o(sleep_o), .bus_lost_o(bus_lost_o));
    bfsp_motion_model bfsp_motion_model_i (.clock_i(clock_i), .rst_i(rst_i),
        .move_i(move_o), .ack_i(ack), .done_o(done));

    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end
    always @(posedge clock_i) if (move_o.valid === 1'b1) seen_q.push_back(move_o);

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_i);
        psel_i   <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= w;
        paddr_i  <= a;
        pwdata_i <= d;
        @(posedge clock_i);
        penable_i <= 1'b1;
        do @(posedge clock_i); while (pready_o !== 1'b1);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb

    task automatic do_reset;
        rst_i <= 1'b1;
        address_strap_two_i <= 1'b0;
        repeat (6) @(posedge clock_i);
        rst_i <= 1'b0;
        seen_q = {};
    endtask : do_reset

    // One bus-loss event; OTP b3 selects the power-on case
    task automatic run_case(input logic [3:0] otp, input logic [10:0] safe,
                            input logic refd, input logic strap);
        logic [17:0]          code;
        logic [10:0]          sp;
        bfsp_pkg::bfsp_move_t m;
        int                   n;
        logic [31:0]          got;
        logic [15:0]          half_mv;
        logic [15:0]          settle_mv;
        do_reset();
        sp = otp[3] ? (safe & 11'h7FC) : safe;
        half_mv   = otp[2] ? bfsp_pkg::HALF_RANGE_DEF : 16'(-bfsp_pkg::HALF_RANGE_DEF);
        settle_mv = otp[2] ? bfsp_pkg::SETTLE_STEPS : 16'(-bfsp_pkg::SETTLE_STEPS);
        if (!otp[3]) apb(1'b1, bfsp_pkg::ADDR_CTRL, 32'h1);
        apb(1'b1, bfsp_pkg::ADDR_OTP, 32'(otp));
        apb(1'b1, bfsp_pkg::ADDR_SAFE, 32'(safe));
        if (refd) apb(1'b1, bfsp_pkg::ADDR_CTRL, 32'h2);
        exp_q = {};
        if (otp[1] && !refd) exp_q.push_back(18'h10000);
        if (otp[1] && !refd && !otp[3]) exp_q.push_back(18'h2000A);
        if (safe != 11'h400) exp_q.push_back(18'(sp));
        if (strap) address_strap_two_i <= 1'b1;
        else begin
            if (!otp[3]) begin
                repeat (LOSS - 1) apb(1'b1, bfsp_pkg::ADDR_CTRL, 32'h20);
                apb(1'b1, bfsp_pkg::ADDR_CTRL, 32'h1);
            end
            repeat (LOSS - 1) apb(1'b1, bfsp_pkg::ADDR_CTRL, 32'h20);
            chk(32'(bus_lost_o), 32'h0);
            apb(1'b1, bfsp_pkg::ADDR_CTRL, 32'h20);
        end
        foreach (exp_q[i]) begin
            code = exp_q[i];
            n = 0;
            while (done !== 1'b1 && n < 3000) begin
                @(posedge clock_i);
                n++;
            end
            chk(32'(done), 32'h1);
            chk(32'(seen_q.size()), 32'h1);
            if (seen_q.size() == 0) return;
            m = seen_q.pop_front();
            got = 32'({m.relative, m.to_stall, m.use_otp, m.pos});
            if (code[16]) chk(got, 32'({3'h7, half_mv}));
            else if (code[17]) chk(got, 32'({3'h5, settle_mv}));
            else chk(32'({got[18:16], got[10:0]}), 32'({2'b00, otp[3], sp}));
            apb(1'b1, bfsp_pkg::ADDR_CTRL, code[16] ? 32'h10 : 32'h8);
            ack <= 1'b1;
            @(posedge clock_i);
            ack <= 1'b0;
            @(posedge clock_i);
            if (code[16]) apb(1'b0, bfsp_pkg::ADDR_CURPOS, 32'h0);
            if (code[16]) chk(rd, 32'h0);
            if (code[17:16] == 2'h0) apb(1'b0, bfsp_pkg::ADDR_TGTPOS, 32'h0);
            if (code[17:16] == 2'h0) chk(32'(rd[10:0]), 32'(code[10:0]));
        end
        repeat (20) @(posedge clock_i);
        chk(32'(seen_q.size()), 32'h0);
        chk(32'({sleep_o, stop_o}), (otp[0] && !strap) ? 32'h2 : 32'h1);
        if (!strap) chk(32'(bus_lost_o), 32'h1);
    endtask : run_case

    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : wrap_up

    initial begin
        #400000;
        fail_count++;
        wrap_up();
    end

    initial begin
        {psel_i, penable_i, pwrite_i, ack, address_strap_two_i} = 5'h00;
        paddr_i = 8'h00;
        pwdata_i = 32'h0;
        rst_i = 1'b1;
        fail_count = 0;
        compares = 0;
        void'($urandom(93));
        do_reset();
        apb(1'b0, bfsp_pkg::ADDR_OTP, 32'h0);
        chk(32'(rd[2:0]), 32'h0);
        apb(1'b0, bfsp_pkg::ADDR_SAFE, 32'h0);
        chk(32'(rd[10:0]), 32'h400);
        apb(1'b0, 8'h40, 32'h0);
        chk({err, rd[30:0]}, 32'h80000000);
        run_case(4'h3, 11'($urandom_range(1023, 0)), 1'b0, 1'b0);
        run_case(4'h2, 11'h1F5, 1'b1, 1'b0);
        run_case(4'hF, 11'h123, 1'b0, 1'b0);
        run_case(4'h8, 11'h3FF, 1'b0, 1'b0);
        run_case(4'h3, 11'h400, 1'b0, 1'b0);
        run_case(4'hB, 11'h055, 1'b0, 1'b1);
        run_case(4'h3, 11'h2AA, 1'b0, 1'b1);
        wrap_up();
    end
endmodule : bfsp_top_tb
